//--- hdp_pkg.sv
/*
 * Shared constants for the handshake/DMA port: control register layout, reset
 * value, mode codes and the AXI4-Lite map of the far end; assumes nothing.
 */
package hdp_pkg;
    // Control register field positions
    localparam int HDP_MODE_HI   = 7;
    localparam int HDP_MODE_LO   = 5;
    localparam int HDP_DEN_BIT   = 4;
    localparam int HDP_DIR_BIT   = 3;
    localparam int HDP_DST_BIT   = 2;
    localparam int HDP_DCH_BIT   = 1;
    localparam int HDP_FIX_BIT   = 0;
    localparam logic [7:0] HDP_CTRL_RESET = 8'hff;
    // Register file offsets of the two port control registers
    localparam logic [7:0] HDP_OFS_CTRL_PORT4 = 8'hf3;
    localparam logic [7:0] HDP_OFS_CTRL_PORT5 = 8'hf7;
    // Mode field codes (bit 7 is don't-care for disabled and bidirectional)
    localparam logic [1:0] HDP_M_LOW_DIS  = 2'h3;
    localparam logic [1:0] HDP_M_LOW_BIDI = 2'h0;
    localparam logic [2:0] HDP_M_OUT2 = 3'h6;
    localparam logic [2:0] HDP_M_OUT1 = 3'h2;
    localparam logic [2:0] HDP_M_IN2  = 3'h5;
    localparam logic [2:0] HDP_M_IN1  = 3'h1;
    typedef enum logic [2:0] {
        HDP_DISABLED, HDP_OUT_2L, HDP_OUT_1L, HDP_IN_2L, HDP_IN_1L, HDP_BIDIR
    } hdp_mode_t;
    // Far-end AXI4-Lite register byte offsets
    localparam logic [3:0] HDP_AXI_CTRL   = 4'h0;
    localparam logic [3:0] HDP_AXI_TXDATA = 4'h4;
    localparam logic [3:0] HDP_AXI_RXDATA = 4'h8;
    localparam logic [3:0] HDP_AXI_STATUS = 4'hc;
    localparam logic [1:0] HDP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] HDP_RESP_SLVERR = 2'h2;
endpackage : hdp_pkg

//--- hdp_link_if.sv
/*
 * Pin-level link between the port (device end) and the external
 * peripheral (far end). Assumes one clock shared by the bench.
 */
`timescale 1ns/1ps
interface hdp_link_if;
    logic       write_strobe_n;  // Peripheral presents inbound data
    logic       write_ready_out; // Device input latches free
    logic       read_strobe_n;   // Peripheral requests outbound data
    logic       read_ready_out;  // Device outbound data valid
    logic [7:0] data_from_dev;
    logic       data_dev_oe;
    logic [7:0] data_from_per;
    logic       data_per_oe;
    logic       timer_capture_input; // AND of both strobes
    modport dev (input write_strobe_n, read_strobe_n, data_from_per, data_per_oe,
                 output write_ready_out, read_ready_out, data_from_dev, data_dev_oe);
    modport per (output write_strobe_n, read_strobe_n, data_from_per, data_per_oe,
                 output timer_capture_input, input write_ready_out, read_ready_out,
                 input data_from_dev, data_dev_oe);
endinterface : hdp_link_if

//--- hdp_port.sv
/*
 * Device end: handshake/DMA controller of one 8-bit parallel port with its
 * control register. Assumes a register-file style bus (single-cycle read and
 * write strobes), a DMA engine that reads or writes the port data register
 * when asked, and timer capture/compare events already in the clk_sys domain.
 */
`timescale 1ns/1ps
// What this block does
// (R1) Mode bits 7..5 select handshake kind
// (R2) Bidir: write pair inbound, read pair outbound
// (R3) Outside ANDs strobes into timer capture
// (R4) Bidir: write ready high while latches free
// (R5) Capture pins while write strobe low
// (R6) Write strobe rise: ready low, request DMA
// (R7) DMA read of port sets write ready
// (R8) Entering bidir: read ready low
// (R9) Slave latch write sets read ready
// (R10) Bidir: drive pins only while read strobe low
// (R11) Read strobe rise: tristate, clear, request
// (R12) DMA write to slave latch sets ready
// (R13) Outbound path is one pipeline stage
// (R14) Software sets direction
// (R15) Compare one-line output: read ready strobes
// (R16) Compare transfer: ready low, then high
// (R17) Control register resets to all ones
// (R18) Bit 4 active-low DMA enable
// (R19) Bit 3: one inbound, zero outbound
// (R20) Bit 2 selects timer event strobe
// (R21) Bit 1: compare one, capture zero
// (R22) Bit 0 always reads one
// (R23) Compare channel forces outbound, loads master
// (R24) Strobes synchronised, edges registered
module hdp_port
    import hdp_pkg::*;
#(
    parameter logic [7:0] REG_OFFSET = HDP_OFS_CTRL_PORT4
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Register file bus
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // DMA engine
    output logic            dma_req,
    input  wire logic       dma_rd_port,
    input  wire logic       dma_wr_port,
    input  wire logic [7:0] dma_wdata,
    output logic      [7:0] port_rdata,
    // Timer events
    input  wire logic       capture_chan_zero,
    input  wire logic       compare_sync_pulse,
    // Link to the peripheral
    hdp_link_if.dev         link
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0] wstb_sync;
        logic [1:0] rstb_sync;
        logic [1:0][7:0] din_sync; // Pins aligned with the strobe sync
        logic       wstb_prev;
        logic       rstb_prev;
        logic       wr_ready;
        logic       rd_ready;
        logic [7:0] in_latch;
        logic [7:0] master;
        logic [7:0] slave;
        logic       pins_oe;
        logic       req;
        logic       cmp_settle;
        hdp_mode_t  mode_prev;
        logic [7:0] rdata;
    } hdp_port_state_t;

    hdp_port_state_t st;
    hdp_port_state_t next_st;
    hdp_mode_t       mode;
    logic            dma_on;
    logic            dir_in;
    logic            use_cmp;
    logic            w_rise;
    logic            r_rise;

    // (R1) decode of the mode field
    always_comb begin
        if (st.ctrl[HDP_MODE_LO+1 -: 2] == HDP_M_LOW_DIS) begin
            mode = HDP_DISABLED;
        end else if (st.ctrl[HDP_MODE_LO+1 -: 2] == HDP_M_LOW_BIDI) begin
            mode = HDP_BIDIR;
        end else if (st.ctrl[HDP_MODE_HI:HDP_MODE_LO] == HDP_M_OUT2) begin
            mode = HDP_OUT_2L;
        end else if (st.ctrl[HDP_MODE_HI:HDP_MODE_LO] == HDP_M_OUT1) begin
            mode = HDP_OUT_1L;
        end else if (st.ctrl[HDP_MODE_HI:HDP_MODE_LO] == HDP_M_IN2) begin
            mode = HDP_IN_2L;
        end else begin
            mode = HDP_IN_1L;
        end
    end

    // (R18) active-low enable; (R21) channel; (R23) compare forces outbound
    assign dma_on  = ~st.ctrl[HDP_DEN_BIT];
    assign use_cmp = st.ctrl[HDP_DCH_BIT];
    // (R19) direction bit, overridden by the compare channel
    assign dir_in  = st.ctrl[HDP_DIR_BIT] & ~use_cmp;
    // (R24) edges seen only on second sync stage and its delayed copy
    assign w_rise  = st.wstb_sync[1] & ~st.wstb_prev;
    assign r_rise  = st.rstb_sync[1] & ~st.rstb_prev;

    // Next-state logic for the whole port
    always_comb begin
        next_st           = st;
        next_st.req       = 1'b0;
        next_st.wstb_sync = {st.wstb_sync[0], link.write_strobe_n};
        next_st.rstb_sync = {st.rstb_sync[0], link.read_strobe_n};
        next_st.din_sync  = {st.din_sync[0],
                             link.data_per_oe ? link.data_from_per : ~link.data_from_per};
        next_st.wstb_prev = st.wstb_sync[1];
        next_st.rstb_prev = st.rstb_sync[1];
        next_st.mode_prev = mode;
        next_st.cmp_settle = 1'b0;

        // (R17) written value keeps bit 0 high; (R22) fixed one
        if (reg_wr && reg_addr == REG_OFFSET) begin
            next_st.ctrl = {reg_wdata[7:1], 1'b1};
        end
        if (reg_rd) begin
            next_st.rdata = (reg_addr == REG_OFFSET) ? st.ctrl : 8'h00;
        end

        // (R8) entering any other mode clears read ready
        if (mode != st.mode_prev) begin
            next_st.rd_ready = 1'b0;
            next_st.wr_ready = 1'b1;
            next_st.pins_oe  = 1'b0;
        end

        if (mode == HDP_BIDIR && dma_on && !use_cmp) begin
            // (R2) inbound pair when direction is one
            if (dir_in) begin
                // (R5) pins follow into latches while the strobe is low
                if (!st.wstb_sync[1] && st.wr_ready) begin
                    next_st.in_latch = st.din_sync[1];
                end
                // (R6) strobe release: full, request
                if (w_rise) begin
                    next_st.wr_ready = 1'b0;
                    next_st.req      = 1'b1;
                end
                // (R7) DMA read frees the latches; (R4) ready held high
                if (dma_rd_port) begin
                    next_st.wr_ready = 1'b1;
                end
            end else begin
                // (R10) drivers on only while read strobe low
                next_st.pins_oe = ~st.rstb_sync[1];
                // (R11) strobe release: tristate, clear, request
                if (r_rise) begin
                    next_st.pins_oe  = 1'b0;
                    next_st.rd_ready = 1'b0;
                    next_st.req      = 1'b1;
                end
                // (R12) (R9) (R13) slave latch load sets ready, next value staged
                if (dma_wr_port) begin
                    next_st.slave    = dma_wdata;
                    next_st.rd_ready = 1'b1;
                end
            end
        end else if (mode == HDP_OUT_1L && dma_on && use_cmp) begin
            // (R23) compare pulse requests the next outbound value
            if (compare_sync_pulse) begin
                next_st.req = 1'b1;
            end
            // (R15) (R16) ready low while latches change, high once settled
            next_st.pins_oe = 1'b1;
            if (dma_wr_port) begin
                next_st.master     = dma_wdata;
                next_st.slave      = dma_wdata;
                next_st.rd_ready   = 1'b0;
                next_st.cmp_settle = 1'b1;
            end
            if (st.cmp_settle) begin
                next_st.rd_ready = 1'b1;
            end
        end else if (dma_on && st.ctrl[HDP_DST_BIT] && capture_chan_zero) begin
            // (R20) timer event strobes the port without handshake
            next_st.req = 1'b1;
            if (dir_in) begin
                next_st.in_latch = st.din_sync[1];
            end
        end else if (dma_wr_port) begin
            // (R9) plain slave latch write
            next_st.slave    = dma_wdata;
            next_st.rd_ready = 1'b1;
        end
    end

    // State register; reset leaves handshake and DMA disabled
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st           <= '0;
            // (R17) all ones after reset
            st.ctrl      <= HDP_CTRL_RESET;
            st.wstb_sync <= 2'h3;
            st.rstb_sync <= 2'h3;
            st.wstb_prev <= 1'b1;
            st.rstb_prev <= 1'b1;
            st.wr_ready  <= 1'b1;
            st.mode_prev <= HDP_DISABLED;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata            = st.rdata;
    assign dma_req              = st.req;
    assign port_rdata           = st.in_latch;
    assign link.write_ready_out = st.wr_ready;
    assign link.read_ready_out  = st.rd_ready;
    assign link.data_from_dev   = st.slave;
    assign link.data_dev_oe     = st.pins_oe;
endmodule : hdp_port

//--- hdp_peripheral.sv
/*
 * Far end: external peripheral that moves bytes over the four-line
 * bidirectional handshake. Software drives it over AXI4-Lite.
 * Assumes the device end keeps its own ready lines honest.
 */
`timescale 1ns/1ps
module hdp_peripheral
    import hdp_pkg::*;
#(
    parameter int STROBE_CYCLES = 6
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Link to the device
    hdp_link_if.per          link
);
    initial begin
        if (STROBE_CYCLES < 6 || STROBE_CYCLES > 255) $error("STROBE_CYCLES out of range");
    end

    typedef enum logic [1:0] { HP_IDLE, HP_SEND, HP_FETCH } hdp_per_state_t;
    typedef struct packed {
        hdp_per_state_t fsm;
        logic [7:0]     cnt;
        logic           wstb_n;
        logic           rstb_n;
        logic           drive;
        logic [7:0]     tx;
        logic [7:0]     rx;
        logic           rx_valid;
        logic           go_send;
        logic           go_fetch;
        logic [1:0]     wr_rdy_s;
        logic [1:0]     rd_rdy_s;
        logic [7:0]     din_s0;
        logic [7:0]     din_s1;
        logic           aw_ok;
        logic           w_ok;
        logic [3:0]     aw_addr;
        logic [7:0]     w_data;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
    } hdp_per_t;

    hdp_per_t s;
    hdp_per_t next_s;

    // Bus handshake, strobe sequencing and pin capture
    always_comb begin
        next_s          = s;
        next_s.wr_rdy_s = {s.wr_rdy_s[0], link.write_ready_out};
        next_s.rd_rdy_s = {s.rd_rdy_s[0], link.read_ready_out};
        next_s.din_s0   = link.data_dev_oe ? link.data_from_dev : ~link.data_from_dev; // Undriven
        next_s.din_s1   = s.din_s0;
        if (s_axi_awvalid && !s.aw_ok && !s.bvalid) begin
            next_s.aw_ok   = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.w_ok && !s.bvalid) begin
            next_s.w_ok   = 1'b1;
            next_s.w_data = s_axi_wdata[7:0];
        end
        // Write executes once address and data have both arrived
        if (s.aw_ok && s.w_ok) begin
            next_s.aw_ok  = 1'b0;
            next_s.w_ok   = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = HDP_RESP_OKAY;
            if (s.aw_addr == HDP_AXI_CTRL) begin
                next_s.go_send  = s.w_data[0];
                next_s.go_fetch = s.w_data[1];
            end else if (s.aw_addr == HDP_AXI_TXDATA) begin
                next_s.tx = s.w_data;
            end else begin
                next_s.bresp = HDP_RESP_SLVERR;
            end
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = HDP_RESP_OKAY;
            if (s_axi_araddr == HDP_AXI_CTRL) begin
                next_s.rdata = {30'h0, s.go_fetch, s.go_send};
            end else if (s_axi_araddr == HDP_AXI_TXDATA) begin
                next_s.rdata = {24'h0, s.tx};
            end else if (s_axi_araddr == HDP_AXI_RXDATA) begin
                next_s.rdata = {24'h0, s.rx};
                next_s.rx_valid = 1'b0;
            end else if (s_axi_araddr == HDP_AXI_STATUS) begin
                next_s.rdata = {28'h0, s.rx_valid, s.rd_rdy_s[1], s.wr_rdy_s[1],
                                s.fsm != HP_IDLE};
            end else begin
                next_s.rdata = 32'h0;
                next_s.rresp = HDP_RESP_SLVERR;
            end
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end

        case (s.fsm)
            HP_IDLE: begin
                next_s.cnt = 8'h00;
                // (R6) load only while write ready is high
                if (s.go_send && s.wr_rdy_s[1]) begin
                    next_s.fsm     = HP_SEND;
                    next_s.go_send = 1'b0;
                    next_s.drive   = 1'b1;
                    next_s.wstb_n  = 1'b0;
                end else if (s.go_fetch && s.rd_rdy_s[1]) begin
                    // (R10) request outbound data with a low read strobe
                    next_s.fsm      = HP_FETCH;
                    next_s.go_fetch = 1'b0;
                    next_s.rstb_n   = 1'b0;
                end
            end
            HP_SEND: begin
                // (R5) data held while the write strobe is low
                next_s.cnt = s.cnt + 8'h01;
                if (s.cnt == 8'(STROBE_CYCLES - 1)) begin
                    next_s.wstb_n = 1'b1;
                    next_s.drive  = 1'b0;
                    next_s.fsm    = HP_IDLE;
                end
            end
            default: begin
                next_s.cnt = s.cnt + 8'h01;
                if (s.cnt == 8'(STROBE_CYCLES - 1)) begin
                    next_s.rx       = s.din_s1;
                    next_s.rx_valid = 1'b1;
                    next_s.rstb_n   = 1'b1;
                    next_s.fsm      = HP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s        <= '0;
            s.fsm    <= HP_IDLE;
            s.wstb_n <= 1'b1;
            s.rstb_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s_axi_awvalid && !s.aw_ok && !s.bvalid;
    assign s_axi_wready  = s_axi_wvalid && !s.w_ok && !s.bvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = s_axi_arvalid && !s.rvalid;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;
    assign link.write_strobe_n = s.wstb_n;
    assign link.read_strobe_n  = s.rstb_n;
    assign link.data_from_per  = s.tx;
    assign link.data_per_oe    = s.drive;
    // (R3) strobes ANDed into the timer capture line
    assign link.timer_capture_input = s.wstb_n & s.rstb_n;
endmodule : hdp_peripheral

//--- hdp_link_sva.sv
/*
 * Checker for the pin link between the port and the peripheral: strobe,
 * ready and data-drive relations. Assumes one clock and plain inputs.
 */
`timescale 1ns/1ps
module hdp_link_sva (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       reset,
    // Link signals
    input wire logic       write_strobe_n,
    input wire logic       write_ready_out,
    input wire logic       read_strobe_n,
    input wire logic       read_ready_out,
    input wire logic [7:0] data_from_dev,
    input wire logic       data_dev_oe,
    input wire logic [7:0] data_from_per,
    input wire logic       data_per_oe,
    input wire logic       timer_capture_input
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    a_capture_and: assert property (
        timer_capture_input == (write_strobe_n & read_strobe_n))
        else $error("capture input is not the strobe AND");
    a_wrdy_drop: assert property ($rose(write_strobe_n) |-> ##3 !write_ready_out)
        else $error("write ready did not drop after strobe");
    a_wait_ready: assert property ($fell(write_strobe_n) |-> $past(write_ready_out))
        else $error("peripheral strobed while port busy");
    a_rrdy_clear: assert property (
        $rose(read_strobe_n) |-> ##3 (!read_ready_out && !data_dev_oe))
        else $error("read strobe end did not clear ready and drive");
    a_drive_on: assert property ($fell(read_strobe_n) |-> ##[1:3] data_dev_oe)
        else $error("port did not drive during read strobe");
    a_no_clash: assert property (!(data_dev_oe && data_per_oe))
        else $error("both ends drive the data pins");
    a_in_stable: assert property (
        (!write_strobe_n && !$past(write_strobe_n)) |-> $stable(data_from_per))
        else $error("inbound data moved during strobe");
    // Only latch updates with ready low may move the driven byte
    a_out_stable: assert property (
        (data_dev_oe && $past(data_dev_oe) && read_ready_out && $past(read_ready_out))
        |-> $stable(data_from_dev))
        else $error("outbound data moved while ready");

    c_inbound: cover property ($rose(write_strobe_n) ##3 !write_ready_out);
    c_outbound: cover property ($rose(read_strobe_n));
    c_compare: cover property ($rose(read_ready_out) && data_dev_oe);
endmodule : hdp_link_sva

//--- testbench.sv
/*
 * Testbench: port and peripheral joined by the link interface; drives the
 * register bus, DMA side and AXI4-Lite. Assumes one 100 MHz clock.
 */
`timescale 1ns/1ps
module testbench import hdp_pkg::*;;
    logic        clk_sys, reset, reg_wr, reg_rd, dma_req, dma_rd_port, dma_wr_port;
    logic        compare_sync_pulse, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, capture_pulse;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, dma_wdata, port_rdata;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd_word;
    logic [1:0]  bresp, rresp;
    int          failures, compares;

    hdp_link_if hdp_link_if_i ();
    hdp_port hdp_port_i (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .dma_req(dma_req), .dma_rd_port(dma_rd_port), .dma_wr_port(dma_wr_port),
        .dma_wdata(dma_wdata), .port_rdata(port_rdata), .capture_chan_zero(capture_pulse),
        .compare_sync_pulse(compare_sync_pulse), .link(hdp_link_if_i));
    hdp_peripheral #(.STROBE_CYCLES(6)) hdp_peripheral_i (.clk_sys(clk_sys),
        .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .link(hdp_link_if_i));
    hdp_link_sva hdp_link_sva_i (.clk_sys(clk_sys), .reset(reset),
        .write_strobe_n(hdp_link_if_i.write_strobe_n),
        .write_ready_out(hdp_link_if_i.write_ready_out),
        .read_strobe_n(hdp_link_if_i.read_strobe_n),
        .read_ready_out(hdp_link_if_i.read_ready_out),
        .data_from_dev(hdp_link_if_i.data_from_dev),
        .data_dev_oe(hdp_link_if_i.data_dev_oe),
        .data_from_per(hdp_link_if_i.data_from_per),
        .data_per_oe(hdp_link_if_i.data_per_oe),
        .timer_capture_input(hdp_link_if_i.timer_capture_input));

    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic give_verdict();
        if (failures == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, wr, !wr};
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= 2'h0;
        @(negedge clk_sys);
    endtask : reg_op

    task automatic dma_op(input logic rd, input logic wr, input logic [7:0] d);
        @(posedge clk_sys);
        {dma_rd_port, dma_wr_port, dma_wdata} <= {rd, wr, d};
        @(posedge clk_sys);
        {dma_rd_port, dma_wr_port} <= 2'h0;
        @(negedge clk_sys);
    endtask : dma_op

    // Requests last one cycle, so they are looked for between edges
    task automatic wait_req();
        for (int n = 0; n < 80; n++) begin
            @(negedge clk_sys);
            if (dma_req === 1'b1) break;
        end
        chk(dma_req, 1'b1);
    endtask : wait_req

    // Write and read side of the AXI4-Lite master; waits are cut by the watchdog
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w, b;
        b = 1'b0;
        @(posedge clk_sys);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        while (!b) begin
            @(negedge clk_sys);
            {aw, w, b} = {awvalid & awready, wvalid & wready, bvalid & bready};
            if (b) chk(bresp, HDP_RESP_OKAY);
            @(posedge clk_sys);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, input logic [1:0] resp);
        logic ar, r;
        r = 1'b0;
        @(posedge clk_sys);
        {araddr, arvalid, rready} <= {a, 2'h3};
        while (!r) begin
            @(negedge clk_sys);
            {ar, r} = {arvalid & arready, rvalid & rready};
            rd_word = rdata;
            if (r) chk(rresp, resp);
            @(posedge clk_sys);
            if (ar) arvalid <= 1'b0;
            if (r) rready <= 1'b0;
        end
    endtask : axi_rd

    task automatic t_regs();
        reg_op(1'b0, HDP_OFS_CTRL_PORT4, 8'h00);
        chk(reg_rdata, HDP_CTRL_RESET);
        for (int i = 0; i < 8; i++) begin
            reg_op(1'b1, HDP_OFS_CTRL_PORT4, {3'(i), 5'h0a});
            reg_op(1'b0, HDP_OFS_CTRL_PORT4, 8'h00);
            chk(reg_rdata, {3'(i), 5'h0b});
        end
        reg_op(1'b0, 8'hf4, 8'h00);
        chk(reg_rdata, 8'h00);
        axi_rd(4'h2, HDP_RESP_SLVERR);
    endtask : t_regs

    task automatic t_inbound();
        reg_op(1'b1, HDP_OFS_CTRL_PORT4, 8'h0d);
        for (int i = 0; i < 2; i++) begin
            chk(hdp_link_if_i.write_ready_out, 1'b1);
            axi_wr(HDP_AXI_TXDATA, 32'h5a + 32'(i) * 32'h81);
            axi_wr(HDP_AXI_CTRL, 32'h1);
            wait_req();
            chk(hdp_link_if_i.write_ready_out, 1'b0);
            chk(port_rdata, 8'h5a + 8'(i) * 8'h81);
            dma_op(1'b1, 1'b0, 8'h00);
            @(negedge clk_sys);
            chk(hdp_link_if_i.write_ready_out, 1'b1);
        end
    endtask : t_inbound

    task automatic t_outbound();
        reg_op(1'b1, HDP_OFS_CTRL_PORT4, 8'h05);
        chk(hdp_link_if_i.read_ready_out, 1'b0);
        for (int i = 0; i < 2; i++) begin
            dma_op(1'b0, 1'b1, 8'hc3 ^ 8'(i * 8'h3c));
            chk(hdp_link_if_i.read_ready_out, 1'b1);
            axi_wr(HDP_AXI_CTRL, 32'h2);
            wait_req();
            chk({hdp_link_if_i.read_ready_out, hdp_link_if_i.data_dev_oe}, 2'h0);
            axi_rd(HDP_AXI_RXDATA, HDP_RESP_OKAY);
            chk(rd_word[7:0], 8'hc3 ^ 8'(i * 8'h3c));
        end
    endtask : t_outbound

    task automatic t_compare();
        reg_op(1'b1, HDP_OFS_CTRL_PORT4, 8'h4f);
        chk(hdp_link_if_i.read_ready_out, 1'b0);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            compare_sync_pulse <= 1'b1;
            @(posedge clk_sys);
            compare_sync_pulse <= 1'b0;
            wait_req();
            dma_op(1'b0, 1'b1, 8'h17 + 8'(i));
            chk(hdp_link_if_i.read_ready_out, 1'b0);
            @(negedge clk_sys);
            chk(hdp_link_if_i.read_ready_out, 1'b1);
            chk({hdp_link_if_i.data_dev_oe, hdp_link_if_i.data_from_dev},
                {1'b1, 8'h17 + 8'(i)});
        end
        reg_op(1'b1, HDP_OFS_CTRL_PORT4, 8'h65);
        @(posedge clk_sys);
        capture_pulse <= 1'b1;
        @(posedge clk_sys);
        capture_pulse <= 1'b0;
        wait_req();
    endtask : t_compare

    task automatic t_reset();
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        reg_op(1'b0, HDP_OFS_CTRL_PORT4, 8'h00);
        chk(reg_rdata, HDP_CTRL_RESET);
        chk({hdp_link_if_i.write_ready_out, hdp_link_if_i.read_ready_out}, 2'h2);
    endtask : t_reset

    // Main sequence: reset, then scenarios in turn
    initial begin
        {reg_addr, reg_wdata, dma_wdata, awaddr, araddr, wdata} = '0;
        {reg_wr, reg_rd, dma_rd_port, dma_wr_port, compare_sync_pulse, capture_pulse} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        failures = 0;
        compares = 0;
        reset = 1'b1;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        t_regs();
        t_inbound();
        t_outbound();
        t_compare();
        t_reset();
        give_verdict();
    end

    // Watchdog: the run needs a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        give_verdict();
    end
endmodule : testbench
